/* rtl/dsf_drive.sv */
// stop-mode sequencer, frequency limiter and AXI4-Lite register slave
`timescale 1ns/10ps
module dsf_drive #(
  parameter int TICK_CYC = dsf_pkg::TICK_CYC,
  parameter int RAMP_STEP = dsf_pkg::RAMP_STEP
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins from the power stage
  input wire logic bus_over_in,
  input wire logic overcur_in,
  // motor drive
  output dsf_pkg::dsf_drive_t drv,
  output logic decel,
  output logic pb_act,
  output logic stall_act
);
  import dsf_pkg::*;
  if (TICK_CYC < 1 || RAMP_STEP < 1 || RAMP_STEP > 1000)
  begin : g_chk
    $error("dsf_drive: bad TICK_CYC or RAMP_STEP");
  end
  // ==========================================================
  // state
  dsf_ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] fref_r, fref_nxt, fstart_r, fstart_nxt, fmax_r, fmax_nxt;
  logic [15:0] clo_r, clo_nxt, chi_r, chi_nxt, finj_r, finj_nxt;
  logic [15:0] toff_r, toff_nxt, tinj_r, tinj_nxt, lvl_r, lvl_nxt;
  logic [15:0] fdw_r, fdw_nxt, freq_r, freq_nxt, cnt_r, cnt_nxt;
  dsf_state_t st_r, st_nxt;
  logic dwelled_r, dwelled_nxt;
  logic [31:0] tcnt_r, tcnt_nxt;
  dsf_drive_t drv_r, drv_nxt;
  logic dec_r, dec_nxt, pb_r, pb_nxt, stl_r, stl_nxt;
  logic bus1_r, bus2_r, oc1_r, oc2_r;
  logic awg_r, awg_nxt, wg_r, wg_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic tick, hold, dwell_on;
  logic [15:0] lim, step, wv;
  logic [31:0] old;
  logic ok;
  function automatic logic [31:0] rd_reg(input logic [7:0] a);
    case (a)
      A_CTRL: rd_reg = {26'h0, ctrl_r};
      A_FREF: rd_reg = {16'h0, fref_r};
      A_FSTART: rd_reg = {16'h0, fstart_r};
      A_FMAX: rd_reg = {16'h0, fmax_r};
      A_CLO: rd_reg = ctrl_r.band_en ? {16'h0, clo_r} : 32'h0;
      A_CHI: rd_reg = ctrl_r.band_en ? {16'h0, chi_r} : 32'h0;
      A_FINJ: rd_reg = {16'h0, finj_r};
      A_TOFF: rd_reg = {16'h0, toff_r};
      A_TINJ: rd_reg = {16'h0, tinj_r};
      A_LVL: rd_reg = {16'h0, lvl_r};
      A_FDWELL: rd_reg = {16'h0, fdw_r};
      A_STAT: rd_reg = {11'h0, st_r, freq_r};
      default: rd_reg = 32'h0;
    endcase
  endfunction
  // ==========================================================
  // combinational next state
  always_comb
  begin
    ctrl_nxt = ctrl_r; fref_nxt = fref_r; fstart_nxt = fstart_r; fmax_nxt = fmax_r;
    clo_nxt = clo_r; chi_nxt = chi_r; finj_nxt = finj_r; toff_nxt = toff_r;
    tinj_nxt = tinj_r; lvl_nxt = lvl_r; fdw_nxt = fdw_r;
    awg_nxt = awg_r; wg_nxt = wg_r; bv_nxt = bv_r; rv_nxt = rv_r;
    br_nxt = br_r; rr_nxt = rr_r; awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
    rd_nxt = rd_r;
    old = 32'h0; wv = 16'h0; ok = 1'b0;
    // bus slave: address and data taken in either order
    if (awvalid && awready)
    begin
      awg_nxt = 1'b1; awa_nxt = {awaddr[7:2], 2'b00};
    end
    if (wvalid && wready)
    begin
      wg_nxt = 1'b1; wd_nxt = wdata; ws_nxt = wstrb;
    end
    if (awg_r && wg_r && !bv_r)
    begin
      old = rd_reg(awa_r);
      for (int i = 0; i < 4; i++)
        if (ws_r[i]) old[i*8 +: 8] = wd_r[i*8 +: 8];
      wv = old[15:0];
      case (awa_r)
        A_CTRL: ok = old[3:1] <= M_PB;
        A_FREF: ok = wv <= fmax_r;
        A_FSTART: ok = wv >= LIM_FSTART_LO && wv <= LIM_FSTART_HI && wv <= fmax_r;
        A_FMAX: ok = wv >= LIM_FMAX_LO && wv <= LIM_FMAX_HI;
        A_CLO: ok = ctrl_r.band_en && wv <= fmax_r;
        A_CHI: ok = ctrl_r.band_en && wv <= fmax_r;
        A_FINJ: ok = wv <= LIM_FINJ && wv <= fmax_r;
        A_TOFF, A_TINJ: ok = wv <= LIM_TIME;
        A_LVL: ok = wv <= LIM_LVL;
        A_FDWELL: ok = wv <= fmax_r;
        default: ok = 1'b0;
      endcase
      if (ok)
      begin
        case (awa_r)
          A_CTRL: ctrl_nxt = old[5:0];
          A_FREF: fref_nxt = wv;
          A_FSTART: fstart_nxt = wv;
          A_FMAX: fmax_nxt = wv;
          A_CLO: clo_nxt = wv;
          A_CHI: chi_nxt = wv;
          A_FINJ: finj_nxt = wv;
          A_TOFF: toff_nxt = wv;
          A_TINJ: tinj_nxt = wv;
          A_LVL: lvl_nxt = wv;
          A_FDWELL: fdw_nxt = wv;
          default: ;
        endcase
      end
      awg_nxt = 1'b0; wg_nxt = 1'b0; bv_nxt = 1'b1;
      br_nxt = ok ? 2'b00 : 2'b10;
    end
    else if (bv_r && bready)
      bv_nxt = 1'b0;
    if (arvalid && arready)
    begin
      rv_nxt = 1'b1; rd_nxt = rd_reg({araddr[7:2], 2'b00});
      rr_nxt = (araddr[7:2] > A_STAT[7:2]) ? 2'b10 : 2'b00;
    end
    else if (rv_r && rready)
      rv_nxt = 1'b0;
  end
  assign awready = !awg_r && !bv_r;
  assign wready = !wg_r && !bv_r;
  assign arready = !rv_r;
  assign bvalid = bv_r;
  assign bresp = br_r;
  assign rvalid = rv_r;
  assign rdata = rd_r;
  assign rresp = rr_r;
  // ==========================================================
  // reference limiter, one path for the bus-written reference fref_r
  always_comb
  begin
    lim = (fref_r > fmax_r) ? fmax_r : fref_r;
    if (ctrl_r.band_en)
    begin
      if (lim < clo_r) lim = clo_r;
      if (lim > chi_r) lim = chi_r;
    end
    if (lim < fstart_r) lim = 16'h0;
  end
  // ==========================================================
  // stop sequencer
  assign tick = tcnt_r == 32'(TICK_CYC - 1);
  assign step = 16'(RAMP_STEP);
  assign hold = pb_r || stl_r;
  assign dwell_on = fdw_r != 16'h0 && !(ctrl_r.mode == M_DCB && fdw_r < finj_r);
  always_comb
  begin
    st_nxt = st_r; freq_nxt = freq_r; cnt_nxt = cnt_r; dwelled_nxt = dwelled_r;
    tcnt_nxt = tick ? 32'h0 : tcnt_r + 32'h1;
    case (st_r)
      ST_IDLE:
      begin
        freq_nxt = 16'h0; dwelled_nxt = 1'b0;
        if (ctrl_r.run) st_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        dwelled_nxt = 1'b0;
        if (!ctrl_r.run)
        begin
          if (ctrl_r.mode == M_FREE)
          begin
            st_nxt = ST_IDLE; freq_nxt = 16'h0;
          end
          else
            st_nxt = ST_DECEL;
        end
        else if (tick)
        begin
          if (freq_r + step <= lim) freq_nxt = freq_r + step;
          else if (freq_r >= lim + step) freq_nxt = freq_r - step;
          else freq_nxt = lim;
        end
      end
      ST_DECEL:
      begin
        if (ctrl_r.run)
          st_nxt = ST_RUN;
        else if (ctrl_r.mode == M_DCB && freq_r <= finj_r)
        begin
          st_nxt = ST_BLOCK; cnt_nxt = 16'h0; freq_nxt = 16'h0;
        end
        else if (freq_r == 16'h0)
          st_nxt = ST_IDLE;
        else if (dwell_on && !dwelled_r && freq_r <= fdw_r)
        begin
          if (cnt_r >= DWELL_CS)
          begin
            dwelled_nxt = 1'b1; cnt_nxt = 16'h0;
          end
          else if (tick) cnt_nxt = cnt_r + 16'h1;
        end
        else if (tick && !hold)
          freq_nxt = (freq_r <= step) ? 16'h0 : freq_r - step;
      end
      ST_BLOCK:
      begin
        if (cnt_r >= toff_r)
        begin
          st_nxt = ST_INJ; cnt_nxt = 16'h0;
        end
        else if (tick) cnt_nxt = cnt_r + 16'h1;
      end
      ST_INJ:
      begin
        if (cnt_r >= tinj_r) st_nxt = ST_IDLE;
        else if (tick) cnt_nxt = cnt_r + 16'h1;
      end
      default: st_nxt = ST_IDLE;
    endcase
    dec_nxt = st_nxt == ST_DECEL;
    pb_nxt = dec_nxt && ctrl_r.mode == M_PB && bus2_r;
    stl_nxt = dec_nxt && ctrl_r.stall_en && ctrl_r.mode != M_PB && oc2_r;
    drv_nxt.freq = freq_nxt;
    drv_nxt.en = st_nxt == ST_RUN || st_nxt == ST_DECEL;
    drv_nxt.inject = st_nxt == ST_INJ;
    // level in percent of rated current
    drv_nxt.level = (st_nxt == ST_INJ) ? lvl_r[7:0] : 8'h0;
  end
  assign drv = drv_r;
  assign decel = dec_r;
  assign pb_act = pb_r;
  assign stall_act = stl_r;
  // ==========================================================
  // registers
  always_ff @(posedge aclk)
  begin
    bus1_r <= bus_over_in; bus2_r <= bus1_r;
    oc1_r <= overcur_in; oc2_r <= oc1_r;
    if (!aresetn)
    begin
      ctrl_r <= '0; fref_r <= 16'h0; fstart_r <= RST_FSTART; fmax_r <= RST_FMAX;
      clo_r <= RST_CLO; chi_r <= RST_FMAX; finj_r <= RST_FINJ; toff_r <= RST_TOFF;
      tinj_r <= RST_TINJ; lvl_r <= RST_LVL; fdw_r <= 16'h0;
      awg_r <= 1'b0; wg_r <= 1'b0; bv_r <= 1'b0; rv_r <= 1'b0;
      br_r <= 2'b00; rr_r <= 2'b00; awa_r <= 8'h0; wd_r <= 32'h0; ws_r <= 4'h0;
      rd_r <= 32'h0;
      st_r <= ST_IDLE; freq_r <= 16'h0; cnt_r <= 16'h0; dwelled_r <= 1'b0;
      tcnt_r <= 32'h0; drv_r <= '0; dec_r <= 1'b0; pb_r <= 1'b0; stl_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt; fref_r <= fref_nxt; fstart_r <= fstart_nxt; fmax_r <= fmax_nxt;
      clo_r <= clo_nxt; chi_r <= chi_nxt; finj_r <= finj_nxt; toff_r <= toff_nxt;
      tinj_r <= tinj_nxt; lvl_r <= lvl_nxt; fdw_r <= fdw_nxt;
      awg_r <= awg_nxt; wg_r <= wg_nxt; bv_r <= bv_nxt; rv_r <= rv_nxt;
      br_r <= br_nxt; rr_r <= rr_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
      rd_r <= rd_nxt;
      st_r <= st_nxt; freq_r <= freq_nxt; cnt_r <= cnt_nxt; dwelled_r <= dwelled_nxt;
      tcnt_r <= tcnt_nxt; drv_r <= drv_nxt; dec_r <= dec_nxt; pb_r <= pb_nxt;
      stl_r <= stl_nxt;
    end
  end
  // ==========================================================
  // checks
  AST_RAMP_END: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_DECEL && !ctrl_r.run && ctrl_r.mode == M_DEC && freq_r == 16'h0
    |=> st_r == ST_IDLE && !drv.en)
    else $error("ramp stop did not halt at zero");
  AST_PB_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    pb_r && st_r == ST_DECEL && !ctrl_r.run |=> $stable(freq_r))
    else $error("power braking let frequency fall");
  AST_INJ_START: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_DECEL && !ctrl_r.run && ctrl_r.mode == M_DCB && freq_r <= finj_r
    |=> st_r == ST_BLOCK && !drv.en && !drv.inject)
    else $error("injection start missed");
  AST_BLOCK_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_BLOCK && $past(st_r) == ST_BLOCK |-> !drv.en && !drv.inject)
    else $error("output on during blocking time");
  AST_INJ_END: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_INJ && cnt_r >= tinj_r |=> st_r == ST_IDLE && !drv.inject)
    else $error("injection overran its duration");
  AST_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    drv.inject && $stable(lvl_r) |-> drv.level == lvl_r[7:0] && lvl_r <= LIM_LVL)
    else $error("injection level wrong");
  AST_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_RUN && !ctrl_r.run && ctrl_r.mode == M_FREE |=> !drv.en && drv.freq == 16'h0)
    else $error("free run did not cut output");
  AST_DECEL_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    pb_act || stall_act |-> decel && st_r == ST_DECEL)
    else $error("braking aid outside deceleration");
  AST_PRIO: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r.mode == M_PB && $past(ctrl_r.mode) == M_PB |-> !stall_act)
    else $error("stall prevention acted with power braking");
  AST_START: assert property (@(posedge aclk) disable iff (!aresetn)
    lim != 16'h0 |-> lim >= fstart_r)
    else $error("reference below start frequency passed");
  AST_MAX: assert property (@(posedge aclk) disable iff (!aresetn)
    fmax_r >= LIM_FMAX_LO && fmax_r <= LIM_FMAX_HI
    && (!$changed(fref_r) || fref_r <= fmax_r))
    else $error("setting above max frequency accepted");
  AST_BAND: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r.band_en && lim != 16'h0 && clo_r <= chi_r |-> lim >= clo_r && lim <= chi_r)
    else $error("band clamp violated");
endmodule // dsf_drive

/* rtl/dsf_pkg.sv */
// constants and types for the drive stop sequencer and frequency limiter
package dsf_pkg;
  // ==========================================================
  // timing: frequency in 0.01 Hz, times in 0.01 s
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int RAMP_STEP = 10;
  localparam logic [15:0] DWELL_CS = 16'h0064;
  // ==========================================================
  // register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FREF = 8'h04;
  localparam logic [7:0] A_FSTART = 8'h08;
  localparam logic [7:0] A_FMAX = 8'h0C;
  localparam logic [7:0] A_CLO = 8'h10;
  localparam logic [7:0] A_CHI = 8'h14;
  localparam logic [7:0] A_FINJ = 8'h18;
  localparam logic [7:0] A_TOFF = 8'h1C;
  localparam logic [7:0] A_TINJ = 8'h20;
  localparam logic [7:0] A_LVL = 8'h24;
  localparam logic [7:0] A_FDWELL = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2C;
  // ==========================================================
  // reset values and limits
  localparam logic [15:0] RST_FSTART = 16'h0032;
  localparam logic [15:0] RST_FMAX = 16'h1770;
  localparam logic [15:0] RST_CLO = 16'h0032;
  localparam logic [15:0] RST_FINJ = 16'h01F4;
  localparam logic [15:0] RST_TOFF = 16'h000A;
  localparam logic [15:0] RST_TINJ = 16'h0064;
  localparam logic [15:0] RST_LVL = 16'h0032;
  localparam logic [15:0] LIM_FSTART_LO = 16'h0001;
  localparam logic [15:0] LIM_FSTART_HI = 16'h03E8;
  localparam logic [15:0] LIM_FMAX_LO = 16'h0FA0;
  localparam logic [15:0] LIM_FMAX_HI = 16'h9C40;
  localparam logic [15:0] LIM_FINJ = 16'h1770;
  localparam logic [15:0] LIM_TIME = 16'h1770;
  localparam logic [15:0] LIM_LVL = 16'h00C8;
  // ==========================================================
  // stop modes and states
  localparam logic [2:0] M_DEC = 3'h0;
  localparam logic [2:0] M_DCB = 3'h1;
  localparam logic [2:0] M_FREE = 3'h2;
  localparam logic [2:0] M_PB = 3'h4;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_RUN = 5'h02, ST_DECEL = 5'h04, ST_BLOCK = 5'h08, ST_INJ = 5'h10
  } dsf_state_t;
  typedef struct packed {
    logic stall_en;
    logic band_en;
    logic [2:0] mode;
    logic run;
  } dsf_ctrl_t;
  typedef struct packed {
    logic [15:0] freq;
    logic en;
    logic inject;
    logic [7:0] level;
  } dsf_drive_t;
endpackage

/* tb/dsf_motor_model.sv */
// behavioural power stage and motor seen from the stop sequencer
`timescale 1ns/10ps
module dsf_motor_model
  import dsf_pkg::*;
(
  // clock
  input wire logic aclk,
  // drive side
  input wire dsf_pkg::dsf_drive_t drv,
  output logic bus_over_in,
  output logic overcur_in,
  // bench commands
  input wire logic regen_cmd,
  input wire logic ovc_cmd
);
  // ==========================================
  // stage feedback
  // regen and overcurrent only exist while the stage is switching
  always @(posedge aclk)
  begin
    bus_over_in <= regen_cmd && (drv.en === 1'b1);
    overcur_in <= ovc_cmd && (drv.en === 1'b1);
  end
endmodule // dsf_motor_model

/* tb/dsf_drive_bench.sv */
// self-checking bench for the stop sequencer and frequency limiter
`timescale 1ns/10ps
module dsf_drive_bench;
  import dsf_pkg::*;
  // ==========================================
  // signals
  // short tick keeps the long ramps and brake times cheap
  localparam int TCK = 10;
  localparam logic [1:0] RS_OK = 2'h0;
  localparam logic [1:0] RS_ERR = 2'h2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  logic regen_cmd = 1'b0, ovc_cmd = 1'b0;
  logic bus_over_in, overcur_in, decel, pb_act, stall_act;
  dsf_drive_t drv;
  int mismatches = 0;
  int checked = 0;

  always #50 aclk = ~aclk;

  // ==========================================
  // design and partner
  dsf_drive #(.TICK_CYC(TCK), .RAMP_STEP(10)) i_dsf_drive (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .bus_over_in(bus_over_in), .overcur_in(overcur_in), .drv(drv), .decel(decel),
    .pb_act(pb_act), .stall_act(stall_act));
  dsf_motor_model i_dsf_motor_model (.aclk(aclk), .drv(drv), .bus_over_in(bus_over_in),
    .overcur_in(overcur_in), .regen_cmd(regen_cmd), .ovc_cmd(ovc_cmd));

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes judged at the falling edge, where they equal the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t)
    begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, e});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, RS_OK});
    chk(d, e);
  endtask

  task automatic wait_freq(input logic [15:0] t);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (drv.freq !== t && n < 5000);
    chk({16'h0, drv.freq}, {16'h0, t});
  endtask

  // sel 0 watches the output enable, 1 the injection flag
  task automatic wait_bit(input int sel, input logic v, output int n);
    logic s;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
      s = (sel == 0) ? drv.en : drv.inject;
    end
    while (s !== v && n < 5000);
  endtask

  task automatic rng(input int n, input int lo, input int hi);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_defaults();
    logic [7:0] a[9] = '{A_CTRL, A_FSTART, A_FMAX, A_CLO, A_CHI, A_FINJ, A_TOFF, A_TINJ, A_LVL};
    logic [15:0] e[9] = '{16'h0000, 16'h0032, 16'h1770, 16'h0000, 16'h0000, 16'h01F4,
      16'h000A, 16'h0064, RST_LVL};
    foreach (a[i]) rchk(a[i], {16'h0, e[i]});
  endtask

  task automatic t_refuse();
    logic [7:0] a[11] = '{A_LVL, A_LVL, A_LVL, A_FMAX, A_FMAX, A_FSTART, A_FSTART, A_CLO,
      A_CTRL, 8'h30, A_FREF};
    logic [15:0] d[11] = '{16'h00C8, 16'h00C9, 16'h0032, 16'h9C41, 16'h0F9F, 16'h0000,
      16'h03E9, 16'h0064, 16'h000A, 16'h0001, 16'h1771};
    logic [1:0] e[11] = '{RS_OK, RS_ERR, RS_OK, RS_ERR, RS_ERR, RS_ERR, RS_ERR, RS_ERR,
      RS_ERR, RS_ERR, RS_ERR};
    foreach (a[i]) wchk(a[i], {16'h0, d[i]}, e[i]);
    rchk(A_FMAX, 32'h0000_1770);
    rchk(A_FSTART, 32'h0000_0032);
  endtask

  task automatic t_start();
    wchk(A_FREF, 32'h0000_0031, RS_OK);
    wchk(A_CTRL, 32'h0000_0001, RS_OK);
    repeat (5 * TCK) @(negedge aclk);
    chk({16'h0, drv.freq}, 32'h0);
    wchk(A_FREF, 32'h0000_0032, RS_OK);
    wait_freq(16'h0032);
    wchk(A_CTRL, 32'h0000_0000, RS_OK);
    wait_freq(16'h0000);
    repeat (TCK) @(negedge aclk);
    rchk(A_STAT, 32'h0001_0000);
  endtask

  task automatic t_band();
    wchk(A_CTRL, 32'h0000_0010, RS_OK);
    wchk(A_CLO, 32'h0000_03E8, RS_OK);
    wchk(A_CHI, 32'h0000_07D0, RS_OK);
    rchk(A_CLO, 32'h0000_03E8);
    wchk(A_FREF, 32'h0000_0BB8, RS_OK);
    wchk(A_CTRL, 32'h0000_0011, RS_OK);
    wait_freq(16'h07D0);
    wchk(A_FREF, 32'h0000_01F4, RS_OK);
    wait_freq(16'h03E8);
  endtask

  task automatic t_dcb();
    int n;
    wchk(A_FDWELL, 32'h0000_012C, RS_OK);
    wchk(A_CTRL, 32'h0000_0012, RS_OK);
    wait_bit(0, 1'b0, n);
    rng(n, 1, 600);
    chk({31'h0, drv.inject}, 32'h0);
    wait_bit(1, 1'b1, n);
    rng(n, 90, 120);
    chk({24'h0, drv.level}, 32'h0000_0032);
    wait_bit(1, 1'b0, n);
    rng(n, 990, 1020);
    chk({15'h0, drv.en, drv.level, drv.freq[7:0]}, 32'h0);
    wchk(A_FDWELL, 32'h0000_0000, RS_OK);
  endtask

  task automatic t_free();
    int n;
    wchk(A_CTRL, 32'h0000_0001, RS_OK);
    wait_freq(16'h01F4);
    wchk(A_CTRL, 32'h0000_0004, RS_OK);
    wait_bit(0, 1'b0, n);
    rng(n, 1, 3);
    chk({16'h0, drv.freq}, 32'h0);
  endtask

  task automatic t_hold(input logic [31:0] stop, input logic [2:0] exp, input logic pb);
    logic [15:0] f;
    wchk(A_CTRL, 32'h0000_0021, RS_OK);
    wait_freq(16'h01F4);
    @(posedge aclk);
    regen_cmd <= pb;
    ovc_cmd <= 1'b1;
    repeat (2 * TCK) @(negedge aclk);
    chk({30'h0, pb_act, stall_act}, 32'h0);
    wchk(A_CTRL, stop, RS_OK);
    repeat (2 * TCK) @(negedge aclk);
    chk({29'h0, decel, pb_act, stall_act}, {29'h0, exp});
    f = drv.freq;
    repeat (3 * TCK) @(negedge aclk);
    chk({16'h0, drv.freq}, {16'h0, f});
    @(posedge aclk);
    regen_cmd <= 1'b0;
    ovc_cmd <= 1'b0;
    wait_freq(16'h0000);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_refuse();
    t_start();
    t_band();
    t_dcb();
    t_free();
    t_hold(32'h0000_0026, 3'b101, 1'b0);
    t_hold(32'h0000_0028, 3'b110, 1'b1);
    finish_test();
  end

  initial
  begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    finish_test();
  end
endmodule // dsf_drive_bench
